// ---- design/smc_pkg.sv ----
// Shared constants and types for the supervisor settings command block
package smc_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_MASK     = 8'h04;
  localparam logic [7:0]  OFF_INTERVAL = 8'h08;
  localparam logic [7:0]  OFF_FLAGS    = 8'h0C;
  localparam logic [7:0]  OFF_STATUS   = 8'h10;
  // Field positions
  localparam int          CTRL_SDI_BIT  = 0;
  localparam int          CTRL_ADDR_LSB = 8;
  localparam int          FLAGS_ERR_BIT = 0;
  localparam int          FLAGS_HEAT_BIT = 1;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_CNT_LSB  = 8;
  localparam int          STAT_EFF_LSB  = 16;
  // Reset values
  localparam logic [15:0] RST_MASK     = 16'hF0C0;
  localparam logic [11:0] RST_INTERVAL = 12'h00F;
  localparam logic        RST_ERR      = 1'b1;
  localparam logic        RST_HEAT     = 1'b1;
  localparam logic [7:0]  RST_ADDR     = 8'h30;
  // Timing: interval unit is one second at the core clock rate
  localparam int          CLK_HZ       = 25000000;
  localparam int          UNIT_S       = 1;
  localparam int          SEC_CYCLES   = CLK_HZ * UNIT_S;
  localparam logic [11:0] HEAT_INTV_S  = 12'h00F;
  localparam logic [11:0] MAX_INTV_S   = 12'hE10;
  // Characters
  localparam logic [7:0]  CH_CR = 8'h0D;
  localparam logic [7:0]  CH_LF = 8'h0A;
  localparam logic [7:0]  CH_EXCL = 8'h21;
  localparam logic [7:0]  CH_AMP = 8'h26;
  localparam logic [7:0]  CH_COMMA = 8'h2C;
  localparam logic [7:0]  CH_ZERO = 8'h30;
  localparam logic [7:0]  CH_ONE = 8'h31;
  localparam logic [7:0]  CH_NINE = 8'h39;
  localparam logic [7:0]  CH_EQ = 8'h3D;
  localparam logic [7:0]  CH_H = 8'h48;
  localparam logic [7:0]  CH_I = 8'h49;
  localparam logic [7:0]  CH_N = 8'h4E;
  localparam logic [7:0]  CH_R = 8'h52;
  localparam logic [7:0]  CH_S = 8'h53;
  localparam logic [7:0]  CH_U = 8'h55;
  localparam logic [7:0]  CH_X = 8'h58;
  localparam logic [7:0]  CH_Y = 8'h59;
  // Reply field codes
  localparam logic [2:0]  FLD_HDR = 3'h0;
  localparam logic [2:0]  FLD_R = 3'h1;
  localparam logic [2:0]  FLD_I = 3'h2;
  localparam logic [2:0]  FLD_S = 3'h3;
  localparam logic [2:0]  FLD_H = 3'h4;
  localparam logic [2:0]  FLD_TERM = 3'h5;

  typedef enum logic [9:0] {
    ST_ADDR = 10'h001, ST_CMD = 10'h002, ST_SDIS = 10'h004,
    ST_U = 10'h008, ST_SEP = 10'h010, ST_FIELD = 10'h020,
    ST_EQ = 10'h040, ST_VAL = 10'h080, ST_SKIP = 10'h100,
    ST_TX = 10'h200
  } smc_fsm_type;

  typedef struct packed {
    smc_fsm_type st;
    logic [15:0] mask;
    logic [11:0] intv;
    logic        errEn;
    logic        heatEn;
    logic        sdi;
    logic [7:0]  devAddr;
    logic [1:0]  curField;
    logic [15:0] valBits;
    logic [4:0]  valCnt;
    logic        ampFirst;
    logic        ampSeen;
    logic [11:0] valNum;
    logic        valBad;
    logic [15:0] pendMask;
    logic        pendAmp;
    logic [11:0] pendIntv;
    logic        pendErr;
    logic        pendHeat;
    logic [3:0]  given;
    logic [3:0]  incl;
    logic        ackOnly;
    logic [2:0]  txField;
    logic [4:0]  txPos;
    logic [7:0]  txChar;
    logic [24:0] preCnt;
    logic [11:0] secCnt;
    logic        tick;
    logic [7:0]  cmdCount;
    logic [31:0] prdata;
  } smc_state_type;
endpackage : smc_pkg

// ---- design/smc_supervisor_cmd.sv ----
// Supervisor settings command interpreter with APB register access
//
// Behaviour
// RQ1: Query with own address replies all four settings, ended by CR LF.
// RQ2: SDI link uses X prefixed keyword ending in '!'; reply echoes it.
// RQ3: Selection is a 16-bit mask; 1 includes a parameter, 0 excludes.
// RQ4: Leftmost eight mask bits select the monitor message contents.
// RQ5: Rightmost eight mask bits select the composite message contents.
// RQ6: First group bits 1-5 select five parameters in order; 6-8 spare.
// RQ7: Bits 9-13 mirror bits 1-5; 14-16 spare; bit 16 rightmost.
// RQ8: Ampersand form changes only bits 9-16; replies show both groups.
// RQ9: Interval 1 to 3600 s accepted; data produced at that interval.
// RQ10: Heating enabled forces the effective interval to 15 s.
// RQ11: Error messaging flag: Y turns on, N turns off.
// RQ12: Heating flag Y enables power switching; N keeps heater off.
// RQ13: Change alters only supplied fields; ASCII echoes them in full.
// RQ14: SDI change acknowledged by address and terminator only.
// RQ15: Composite selection gathers second-group masks of all sensors.
// RQ16: Spare mask bits stored and reported but never steer output.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module smc_supervisor_cmd #(
  parameter int SEC_CYCLES_P = smc_pkg::SEC_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             rxReady,
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  input  wire logic [7:0]  windSel,
  input  wire logic [7:0]  ptuSel,
  input  wire logic [7:0]  rainSel,
  output logic [4:0]       monitorSel,
  output logic [28:0]      compositeSel,
  output logic             errMsgEnable,
  output logic             heaterAuto,
  output logic             updateTick
);
  import smc_pkg::*;

  smc_state_type s_ff;
  smc_state_type nxt_s;

  // Mapped register offsets
  function automatic logic addrOk(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_MASK || a == OFF_INTERVAL ||
           a == OFF_FLAGS || a == OFF_STATUS;
  endfunction : addrOk

  function automatic logic isTerm(input logic [7:0] c, input logic sdi);
    return sdi ? (c == CH_EXCL) : (c == CH_LF);
  endfunction : isTerm

  function automatic logic [2:0] numDigits(input logic [11:0] v);
    return (v >= 12'd1000) ? 3'd4 : (v >= 12'd100) ? 3'd3 :
           (v >= 12'd10) ? 3'd2 : 3'd1;
  endfunction : numDigits

  // Decimal digits, index 0 is thousands
  function automatic logic [3:0][3:0] digitsOf(input logic [11:0] v);
    logic [3:0][3:0] d;
    d[0] = 4'(v / 12'd1000);
    d[1] = 4'((v / 12'd100) % 12'd10);
    d[2] = 4'((v / 12'd10) % 12'd10);
    d[3] = 4'(v % 12'd10);
    return d;
  endfunction : digitsOf

  function automatic logic fieldLast(input logic [2:0] f,
      input logic [4:0] p, input logic [2:0] nd, input logic ack);
    logic r;
    r = 1'b0;
    case (f)
      FLD_HDR:  r = ack ? (p == 5'd0) : (p == 5'd3);
      FLD_R:    r = (p == 5'd19);
      FLD_I:    r = (p == 5'(nd) + 5'd2);
      FLD_TERM: r = (p == 5'd1);
      default:  r = (p == 5'd3);
    endcase
    return r;
  endfunction : fieldLast

  // Character at position p of reply field f
  function automatic logic [7:0] charAt(input logic [2:0] f,
      input logic [4:0] p, input smc_state_type s);
    logic [7:0]      c;
    logic [4:0]      k;
    logic [2:0]      nd;
    logic [3:0][3:0] dg;
    logic [1:0]      idx;
    c = CH_CR;
    k = 5'(p - 5'd3);
    nd = numDigits(s.intv);
    dg = digitsOf(s.intv);
    idx = 2'(3'd4 - nd + 3'(k));
    if (f == FLD_HDR) begin
      c = (p == 5'd0) ? s.devAddr : (p == 5'd1) ? CH_X :
          (p == 5'd2) ? CH_S : CH_U;
    end else if (f == FLD_TERM) begin
      c = (p == 5'd0) ? CH_CR : CH_LF;
    end else if (p == 5'd0) begin
      c = CH_COMMA;
    end else if (p == 5'd1) begin
      c = (f == FLD_R) ? CH_R : (f == FLD_I) ? CH_I :
          (f == FLD_S) ? CH_S : CH_H;
    end else if (p == 5'd2) begin
      c = CH_EQ;
    end else begin
      case (f)
        FLD_R: c = (k < 5'd8) ? (s.mask[4'(5'd15 - k)] ? CH_ONE : CH_ZERO) :
                   (k == 5'd8) ? CH_AMP :
                   (s.mask[4'(5'd16 - k)] ? CH_ONE : CH_ZERO); // RQ8
        FLD_I: c = CH_ZERO + 8'(dg[idx]);
        FLD_S: c = s.errEn ? CH_Y : CH_N;
        default: c = s.heatEn ? CH_Y : CH_N;
      endcase
    end
    return c;
  endfunction : charAt

  logic        rxFire;
  logic        txFire;
  logic        apbWr;
  logic        commitAmp;
  logic [11:0] effIntv;

  // Next-state logic for parser, reply sequencer, timer and registers
  always_comb begin
    logic [7:0]  c;
    logic        ok;
    logic        fin;
    logic [16:0] tmp;
    logic [2:0]  nf;
    c = rxData;
    ok = 1'b0;
    fin = 1'b0;
    tmp = 17'h00000;
    nf = FLD_TERM;
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    commitAmp = 1'b0;
    rxFire = rxValid && (s_ff.st != ST_TX);
    txFire = (s_ff.st == ST_TX) && txReady;
    apbWr = psel && penable && pwrite;
    effIntv = s_ff.heatEn ? HEAT_INTV_S : s_ff.intv; // RQ10
    // Register writes; a command commit later in this process wins
    if (apbWr) begin
      if (paddr == OFF_CTRL) begin
        nxt_s.sdi = pwdata[CTRL_SDI_BIT];
        nxt_s.devAddr = pwdata[CTRL_ADDR_LSB +: 8];
      end
      if (paddr == OFF_MASK) nxt_s.mask = pwdata[15:0]; // RQ3
      if (paddr == OFF_INTERVAL && pwdata[11:0] != 12'h000 &&
          pwdata[11:0] <= MAX_INTV_S && pwdata[31:12] == 20'h00000)
        nxt_s.intv = pwdata[11:0]; // RQ9
      if (paddr == OFF_FLAGS) begin
        nxt_s.errEn = pwdata[FLAGS_ERR_BIT];
        nxt_s.heatEn = pwdata[FLAGS_HEAT_BIT];
      end
    end
    // Read data captured in the setup phase
    if (psel && !penable) begin
      nxt_s.prdata = 32'h00000000;
      case (paddr)
        OFF_CTRL: begin
          nxt_s.prdata[CTRL_SDI_BIT] = s_ff.sdi;
          nxt_s.prdata[CTRL_ADDR_LSB +: 8] = s_ff.devAddr;
        end
        OFF_MASK:     nxt_s.prdata[15:0] = s_ff.mask;
        OFF_INTERVAL: nxt_s.prdata[11:0] = s_ff.intv;
        OFF_FLAGS: begin
          nxt_s.prdata[FLAGS_ERR_BIT] = s_ff.errEn;
          nxt_s.prdata[FLAGS_HEAT_BIT] = s_ff.heatEn;
        end
        OFF_STATUS: begin
          nxt_s.prdata[STAT_BUSY_BIT] = (s_ff.st != ST_ADDR);
          nxt_s.prdata[STAT_CNT_LSB +: 8] = s_ff.cmdCount;
          nxt_s.prdata[STAT_EFF_LSB +: 12] = effIntv;
        end
        default: nxt_s.prdata = 32'h00000000;
      endcase
    end
    // Command parser; CR is ignored on the ASCII link, LF ends a line
    if (rxFire && !(!s_ff.sdi && c == CH_CR)) begin
      unique case (s_ff.st)
        ST_ADDR: if (!isTerm(c, s_ff.sdi)) begin
          nxt_s.st = (c == s_ff.devAddr) ? ST_CMD : ST_SKIP; // RQ1
          nxt_s.given = 4'h0;
        end
        ST_CMD: nxt_s.st = s_ff.sdi ? ((c == CH_X) ? ST_SDIS : ST_SKIP)
                                    : ((c == CH_S) ? ST_U : ST_SKIP); // RQ2
        ST_SDIS: nxt_s.st = (c == CH_S) ? ST_U : ST_SKIP; // RQ2
        ST_U: nxt_s.st = (c == CH_U) ? ST_SEP : ST_SKIP;
        ST_SEP: begin
          if (c == CH_COMMA) nxt_s.st = ST_FIELD;
          else if (isTerm(c, s_ff.sdi)) fin = 1'b1; // RQ1
          else nxt_s.st = ST_SKIP;
        end
        ST_FIELD: begin
          nxt_s.st = ST_EQ;
          if (c == CH_R) nxt_s.curField = 2'd0;
          else if (c == CH_I) nxt_s.curField = 2'd1;
          else if (c == CH_S) nxt_s.curField = 2'd2;
          else if (c == CH_H) nxt_s.curField = 2'd3;
          else nxt_s.st = ST_SKIP;
        end
        ST_EQ: begin
          nxt_s.st = (c == CH_EQ) ? ST_VAL : ST_SKIP;
          nxt_s.valBits = 16'h0000;
          nxt_s.valCnt = 5'h00;
          nxt_s.ampFirst = 1'b0;
          nxt_s.ampSeen = 1'b0;
          nxt_s.valNum = 12'h000;
          nxt_s.valBad = 1'b0;
        end
        ST_VAL: begin
          if (c == CH_COMMA || isTerm(c, s_ff.sdi)) begin
            // Field complete: validate and stage it
            case (s_ff.curField)
              2'd0: ok = s_ff.ampFirst ? (s_ff.valCnt == 5'd8) :
                         (s_ff.valCnt == 5'd16 && s_ff.ampSeen); // RQ8
              2'd1: ok = !s_ff.valBad && s_ff.valNum != 12'h000; // RQ9
              default: ok = (s_ff.valCnt == 5'd1); // RQ11 RQ12
            endcase
            // Only an R field may stage a mask; later fields leave it be
            if (s_ff.curField == 2'd0) begin
              nxt_s.pendMask = s_ff.valBits;
              nxt_s.pendAmp = s_ff.ampFirst;
            end
            if (s_ff.curField == 2'd1) nxt_s.pendIntv = s_ff.valNum;
            if (s_ff.curField == 2'd2) nxt_s.pendErr = s_ff.valBits[0];
            if (s_ff.curField == 2'd3) nxt_s.pendHeat = s_ff.valBits[0];
            if (!ok) nxt_s.st = ST_SKIP;
            else begin
              nxt_s.given[s_ff.curField] = 1'b1; // RQ13
              if (c == CH_COMMA) nxt_s.st = ST_FIELD;
              else fin = 1'b1;
            end
          end else if (s_ff.curField == 2'd0) begin
            if ((c == CH_ZERO || c == CH_ONE) && s_ff.valCnt < 5'd16) begin
              nxt_s.valBits = {s_ff.valBits[14:0], c == CH_ONE};
              nxt_s.valCnt = s_ff.valCnt + 5'd1;
            end else if (c == CH_AMP && !s_ff.ampSeen &&
                         (s_ff.valCnt == 5'd0 || s_ff.valCnt == 5'd8)) begin
              nxt_s.ampSeen = 1'b1;
              nxt_s.ampFirst = (s_ff.valCnt == 5'd0); // RQ8
            end else nxt_s.st = ST_SKIP;
          end else if (s_ff.curField == 2'd1) begin
            if (c >= CH_ZERO && c <= CH_NINE) begin
              tmp = 17'(s_ff.valNum) * 17'd10 + 17'(c - CH_ZERO);
              if (tmp > 17'(MAX_INTV_S)) nxt_s.valBad = 1'b1; // RQ9
              else nxt_s.valNum = 12'(tmp);
            end else nxt_s.st = ST_SKIP;
          end else if ((c == CH_Y || c == CH_N) && s_ff.valCnt == 5'd0) begin
            nxt_s.valBits[0] = (c == CH_Y); // RQ11
            nxt_s.valCnt = 5'd1;
          end else nxt_s.st = ST_SKIP;
        end
        ST_SKIP: if (isTerm(c, s_ff.sdi)) nxt_s.st = ST_ADDR;
        ST_TX: nxt_s.st = ST_TX;
        default: nxt_s.st = ST_ADDR;
      endcase
      // A refused line ends at its own terminator, so the next is heard
      if (nxt_s.st == ST_SKIP && isTerm(c, s_ff.sdi)) nxt_s.st = ST_ADDR;
    end
    // Commit only the fields supplied, then start the reply
    if (fin) begin
      if (nxt_s.given[0]) begin
        commitAmp = nxt_s.pendAmp;
        nxt_s.mask = nxt_s.pendAmp ? {s_ff.mask[15:8], nxt_s.pendMask[7:0]}
                                   : nxt_s.pendMask; // RQ8 RQ13
      end
      if (nxt_s.given[1]) nxt_s.intv = nxt_s.pendIntv; // RQ13
      if (nxt_s.given[2]) nxt_s.errEn = nxt_s.pendErr;
      if (nxt_s.given[3]) nxt_s.heatEn = nxt_s.pendHeat;
      nxt_s.incl = (nxt_s.given == 4'h0) ? 4'hF :
                   (s_ff.sdi ? 4'h0 : nxt_s.given); // RQ1 RQ13 RQ14
      nxt_s.ackOnly = s_ff.sdi && nxt_s.given != 4'h0; // RQ14
      nxt_s.st = ST_TX;
      nxt_s.txField = FLD_HDR;
      nxt_s.txPos = 5'd0;
      nxt_s.cmdCount = s_ff.cmdCount + 8'h01;
    end
    // Reply sequencer
    if (txFire) begin
      if (fieldLast(s_ff.txField, s_ff.txPos, numDigits(s_ff.intv),
                    s_ff.ackOnly)) begin
        for (int i = 4; i >= 1; i--)
          if (i > int'(s_ff.txField) && s_ff.incl[i-1]) nf = 3'(i);
        if (s_ff.txField == FLD_TERM) nxt_s.st = ST_ADDR;
        nxt_s.txField = nf;
        nxt_s.txPos = 5'd0;
      end else if (s_ff.txField == FLD_HDR && s_ff.txPos == 5'd0 &&
                   !s_ff.sdi) begin
        nxt_s.txPos = 5'd2; // RQ2
      end else nxt_s.txPos = s_ff.txPos + 5'd1;
    end
    nxt_s.txChar = charAt(nxt_s.txField, nxt_s.txPos, nxt_s);
    // One-second prescaler and interval counter
    if (s_ff.preCnt == 25'(SEC_CYCLES_P - 1)) begin
      nxt_s.preCnt = 25'h0000000;
      if (s_ff.secCnt + 12'd1 >= effIntv) begin
        nxt_s.secCnt = 12'h000;
        nxt_s.tick = 1'b1; // RQ9 RQ10
      end else nxt_s.secCnt = s_ff.secCnt + 12'd1;
    end else begin
      nxt_s.preCnt = s_ff.preCnt + 25'd1;
    end
    // An interval at or below the running count restarts it at once, never overshooting
    if (nxt_s.secCnt >= (nxt_s.heatEn ? HEAT_INTV_S : nxt_s.intv))
      nxt_s.secCnt = 12'h000; // RQ9 RQ10
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.st <= ST_ADDR;
      s_ff.mask <= RST_MASK;
      s_ff.intv <= RST_INTERVAL;
      s_ff.errEn <= RST_ERR;
      s_ff.heatEn <= RST_HEAT;
      s_ff.devAddr <= RST_ADDR;
      s_ff.txChar <= RST_ADDR;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs; spare bits never reach the message selections
  assign prdata = s_ff.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk(paddr);
  assign rxReady = (s_ff.st != ST_TX);
  assign txValid = (s_ff.st == ST_TX);
  assign txData = s_ff.txChar;
  assign monitorSel = s_ff.mask[15:11]; // RQ4 RQ6 RQ16
  // Bits 9-13 join the other sensors' second-group masks
  assign compositeSel = {windSel, ptuSel, rainSel,
                         s_ff.mask[7:3]}; // RQ5 RQ7 RQ15
  assign errMsgEnable = s_ff.errEn; // RQ11
  assign heaterAuto = s_ff.heatEn; // RQ12
  assign updateTick = s_ff.tick;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reply_header: assert property ($rose(txValid) |-> txData == s_ff.devAddr)
    else $error("reply does not open with address"); // RQ1
  a_reply_start: assert property (s_ff.st == ST_SEP && rxFire &&
      isTerm(rxData, s_ff.sdi) |=> txValid && s_ff.incl == 4'hF)
    else $error("query did not start full reply"); // RQ1
  a_sdi_prefix: assert property (txFire && s_ff.txField == FLD_HDR &&
      s_ff.txPos == 5'd0 && s_ff.sdi && !s_ff.ackOnly |=> txData == CH_X)
    else $error("sdi reply lacks X prefix"); // RQ2
  a_amp_keep: assert property (commitAmp |=>
      s_ff.mask[15:8] == $past(s_ff.mask[15:8]))
    else $error("ampersand form altered first group"); // RQ8
  a_heat_force: assert property (s_ff.heatEn |-> s_ff.secCnt < HEAT_INTV_S)
    else $error("heating did not force interval"); // RQ10
  a_intv_range: assert property (s_ff.intv != 12'h000 &&
      s_ff.intv <= MAX_INTV_S && s_ff.secCnt <= effIntv)
    else $error("interval out of range"); // RQ9
  a_sdi_ack: assert property (txFire && s_ff.ackOnly &&
      s_ff.txField == FLD_HDR |=>
      s_ff.txField == FLD_TERM && txData == CH_CR)
    else $error("sdi change ack not address only"); // RQ14
  a_term_pair: assert property (txFire && s_ff.txField == FLD_TERM &&
      s_ff.txPos == 5'd0 |=> txValid && txData == CH_LF)
    else $error("CR not followed by LF"); // RQ1
  a_rx_stall: assert property (txValid |-> !rxReady)
    else $error("input accepted during reply"); // RQ13
  a_spare_mute: assert property ($changed(s_ff.mask[10:8]) &&
      $stable(s_ff.mask[15:11]) |-> $stable(monitorSel))
    else $error("spare bit changed selection"); // RQ16

  c_query: cover property (s_ff.st == ST_SEP && rxFire &&
      isTerm(rxData, s_ff.sdi));
  c_amp: cover property (commitAmp);
  c_sdi_ack: cover property (txValid && s_ff.ackOnly);
  c_tick: cover property (updateTick && s_ff.heatEn);
endmodule : smc_supervisor_cmd

// ---- tb/smc_host_model.sv ----
// Host model that sends command lines and collects reply characters
`timescale 1ns/1ps
module smc_host_model (
  input  wire logic       core_clk,
  input  wire logic       rxReady,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            txReady
);
  logic [7:0] got[$];
  bit         slow;

  // Idle levels at time zero
  initial begin
    slow    = 1'b0;
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b1;
  end

  // One command line; ready is judged at the falling edge to avoid races
  task automatic send(input string body, input bit sdi);
    string line;
    line = sdi ? {body, "!"} : {body, "\r\n"};
    for (int i = 0; i < line.len(); i++) begin
      rxValid <= 1'b1;
      rxData  <= line[i];
      forever begin
        @(negedge core_clk);
        if (rxReady === 1'b1) break;
      end
      @(posedge core_clk);
    end
    rxValid <= 1'b0;
    rxData  <= ~line[line.len() - 1]; // Released line shows no stale char
  endtask : send

  // Reply sink; slow mode stalls every other cycle
  always @(posedge core_clk) begin
    if (txValid === 1'b1 && txReady) got.push_back(txData);
    txReady <= slow ? ~txReady : 1'b1;
  end
endmodule : smc_host_model

// ---- tb/tb_supervisor_settings_cmd.sv ----
// Testbench for the supervisor settings command block
`timescale 1ns/1ps
module tb_supervisor_settings_cmd;
  import smc_pkg::*;
  localparam int SEC = 20;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        rxValid, rxReady, txValid, txReady, errSeen;
  logic        errMsgEnable, heaterAuto, updateTick;
  logic [7:0]  paddr, rxData, txData, windSel, ptuSel, rainSel;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  monitorSel;
  logic [28:0] compositeSel;
  logic [7:0]  ra [4] = '{OFF_MASK, OFF_INTERVAL, OFF_FLAGS, OFF_CTRL};
  logic [31:0] rv [4] = '{32'h0000F0C0, 32'h0000000F, 32'h3, 32'h3000};
  int          bad_count = 0;
  int          total_checks = 0;

  smc_supervisor_cmd #(.SEC_CYCLES_P(SEC)) DUT (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txReady(txReady), .windSel(windSel),
    .ptuSel(ptuSel), .rainSel(rainSel), .monitorSel(monitorSel),
    .compositeSel(compositeSel), .errMsgEnable(errMsgEnable),
    .heaterAuto(heaterAuto), .updateTick(updateTick));

  smc_host_model host (
    .core_clk(core_clk), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .rxValid(rxValid), .rxData(rxData),
    .txReady(txReady));

  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic fail(input string what);
    bad_count++;
    $display("mismatch at %0t: %s", $time, what);
  endtask : fail

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask : check

  // APB transfer; holds the request until pready is seen high
  task automatic apb(input bit wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd      = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Waits for a whole reply, then a quiet spell to catch extra characters
  task automatic expect_reply(input string exp);
    int n;
    n = 0;
    while (host.got.size() < exp.len() && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (40) @(posedge core_clk);
    total_checks++;
    if (host.got.size() != exp.len()) fail({"reply length: ", exp});
    else for (int i = 0; i < exp.len(); i++) begin
      if (host.got[i] !== exp[i]) begin
        fail({"reply text: ", exp});
        break;
      end
    end
    host.got.delete();
  endtask : expect_reply

  // Skips stale gaps left from the previous interval, measures the last
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (updateTick !== 1'b1 && n < 1000);
    end
    check(n, exp, "tick gap");
  endtask : tick_gap

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail("timeout");
    wrap_up;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {windSel, ptuSel, rainSel} = {8'hA5, 8'h3C, 8'h81};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check(rd, rv[i], "reset value");
    end
    apb(1'b1, 8'h14, 32'hFFFF);
    check(errSeen, 1'b1, "unmapped pslverr");
    host.send("0SU", 1'b0);
    expect_reply("0SU,R=11110000&11000000,I=15,S=Y,H=Y\r\n");
    check(monitorSel, 5'b11110, "monitor sel");
    check(compositeSel, {24'hA53C81, 5'b11000}, "composite");
    host.send("0SU,R=&00001111", 1'b0);
    expect_reply("0SU,R=11110000&00001111\r\n");
    check(compositeSel[4:0], 5'b00001, "amp composite");
    check(monitorSel, 5'b11110, "amp keeps group one");
    apb(1'b0, OFF_MASK, 32'h0);
    check(rd, 32'h0000F00F, "spare bits stored");
    host.send("0SU,R=10000001&00000111", 1'b0);
    expect_reply("0SU,R=10000001&00000111\r\n");
    check(monitorSel, 5'b10000, "full mask monitor");
    check(compositeSel[4:0], 5'b00000, "full mask comp");
    host.send("0SU,S=N,H=N", 1'b0);
    expect_reply("0SU,S=N,H=N\r\n");
    check({errMsgEnable, heaterAuto}, 2'b00, "flags off");
    host.send("0SU,R=&00000111,I=3,S=Y", 1'b0);
    expect_reply("0SU,R=10000001&00000111,I=3,S=Y\r\n");
    check({errMsgEnable, heaterAuto}, 2'b10, "subset only");
    tick_gap(3 * SEC);
    host.send("0SU,I=3601", 1'b0);
    expect_reply("");
    host.send("1SU", 1'b0);
    expect_reply("");
    apb(1'b0, OFF_INTERVAL, 32'h0);
    check(rd, 32'h3, "range refused");
    host.send("0SU,I=3600", 1'b0);
    expect_reply("0SU,I=3600\r\n");
    host.send("0SU,H=Y", 1'b0);
    expect_reply("0SU,H=Y\r\n");
    check(heaterAuto, 1'b1, "heat on");
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h000F0700, "status forced interval");
    tick_gap(15 * SEC);
    apb(1'b1, OFF_CTRL, 32'h3001);
    host.slow = 1'b1;
    host.send("0XSU,I=10", 1'b1);
    expect_reply("0\r\n");
    host.send("0XSU", 1'b1);
    expect_reply("0XSU,R=10000001&00000111,I=10,S=Y,H=Y\r\n");
    wrap_up;
  end
endmodule : tb_supervisor_settings_cmd
